/* pkg/pdm_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * of the power-down mode controller.
 * Assumes inclusion by bare name from the design files and the testbench.
 */
// What this block does
// [R1] Sleep halts core; wakes on reset/interrupt
// [R2] I/O stop halts peripherals; software clears it
// [R3] System stop halts core and peripherals
// [R4] Idle also stops clock output; bus request wakes
// [R5] Standby also stops oscillator and clocks
// [R6] Control bits 6,3 = 1,0 select standby
// [R7] Software: mode bits, stop bit, then sleep
// [R8] Standby wake: restart oscillator, count 2^17
// [R9] Quick recovery shortens wait to 2^6
// [R10] Dropped request before count returns to standby
// [R11] Reset exit restarts at address 0000H
// [R12] Reset in standby restarts clocks immediately
// [R13] Minimum recovery applies to interrupt wake
// [R14] Bits 6,3 = 0,1 select idle
// [R15] Both bits clear select system stop
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH
`define PDM_CPU_CONTROL_ADDR  8'h1f
`define PDM_IO_CONTROL_ADDR   8'h3f
`define PDM_STBY_BIT          6
`define PDM_IDLE_BIT          3
`define PDM_QUICK_BIT         7
`define PDM_IOSTOP_BIT        5
`define PDM_CPU_CONTROL_RST   8'h00
`define PDM_IO_CONTROL_RST    8'h00
`define PDM_RESET_VECTOR      16'h0000
`define PDM_CNT_W             18
`define PDM_NORMAL_COUNT      18'h20000
`define PDM_QUICK_COUNT       18'h00040
`define PDM_IDLE_COUNT        18'h00008
`define PDM_FRAC_COUNT        18'h00002
`endif

/* pkg/pdm_pkg.sv */
/*
 * Types of the power-down mode controller.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package pdm_pkg;
    // Power state of the controller
    typedef enum logic [2:0] {
        PDM_RUN, PDM_SLEEP, PDM_SYSSTOP, PDM_IDLE, PDM_STANDBY, PDM_WAKE
    } pdm_state_t;
endpackage
`default_nettype wire

/* rtl/pdm_counter.sv */
/*
 * Stabilisation counter: loads a target, counts down to zero and flags done at one.
 * Assumes a synchronous active-high reset on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_regs.svh"
module pdm_counter (
    input  wire logic                   ref_clk,  // System clock
    input  wire logic                   rst,      // Synchronous reset
    input  wire logic                   load,     // Restart the count
    input  wire logic [`PDM_CNT_W-1:0]  target,   // Cycles to wait
    input  wire logic                   run,      // Count while high
    output logic                        done      // Wait elapsed
);
    logic [`PDM_CNT_W-1:0] cnt_q, cnt_d;  // Remaining cycles

    // Next count
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = target;
        end else if (run && cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = run && !load && cnt_q == {{(`PDM_CNT_W-1){1'b0}}, 1'b1};
endmodule // pdm_counter
`default_nettype wire

/* rtl/pdm_ctrl.sv */
/*
 * Power-down mode controller: two control registers, mode decode,
 * clock gating outputs and wake sequencing with stabilisation wait.
 * Assumes an internal I/O bus on ref_clk and asynchronous wake pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_regs.svh"
module pdm_ctrl (
    input  wire logic        ref_clk,          // System clock, 125 MHz
    input  wire logic        rst,              // Synchronous reset
    input  wire logic [7:0]  io_addr,          // I/O address
    input  wire logic [7:0]  io_wdata,         // Write data
    input  wire logic        io_wr,            // Write strobe
    input  wire logic        io_rd,            // Read strobe
    output logic      [7:0]  io_rdata,         // Read data
    input  wire logic        sleep_exec,       // Sleep instruction pulse
    input  wire logic        irq_in,           // Interrupt request pin
    input  wire logic        bus_request_in,   // Bus request pin
    output logic             wake_ack,         // Acknowledge to source
    output logic             core_run,         // CPU core clock enable
    output logic             periph_run,       // Peripheral clock enable
    output logic             osc_run,          // Oscillator enable
    output logic             clock_output,     // Clock output enable
    output logic      [15:0] start_addr        // Fetch address at reset
);
    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    logic [1:0] irq_s_q, breq_s_q;  // Two-stage chains
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_s_q  <= 2'h0;
            breq_s_q <= 2'h0;
        end else begin
            irq_s_q  <= {irq_s_q[0], irq_in};
            breq_s_q <= {breq_s_q[0], bus_request_in};
        end
    end
    wire irq  = irq_s_q[1];   // Synced interrupt
    wire breq = breq_s_q[1];  // Synced bus request

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [7:0] cpu_control_q, cpu_control_d;  // Mode select
    logic [7:0] io_control_q, io_control_d;    // Peripheral stop
    logic [7:0] rdata_q, rdata_d;              // Read data

    // Address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Register writes and reads
    always_comb begin
        cpu_control_d = cpu_control_q;
        io_control_d  = io_control_q;
        rdata_d       = rdata_q;
        if (io_wr && hit(io_addr, `PDM_CPU_CONTROL_ADDR)) begin
            cpu_control_d = io_wdata;
        end
        if (io_wr && hit(io_addr, `PDM_IO_CONTROL_ADDR)) begin
            io_control_d = io_wdata;  // Clearing bit 5 ends I/O stop [R2]
        end
        if (io_rd) begin
            if (hit(io_addr, `PDM_CPU_CONTROL_ADDR)) begin
                rdata_d = cpu_control_q;
            end else if (hit(io_addr, `PDM_IO_CONTROL_ADDR)) begin
                rdata_d = io_control_q;
            end else begin
                rdata_d = 8'h00;  // Unmapped reads zero
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_control_q <= `PDM_CPU_CONTROL_RST;
            io_control_q  <= `PDM_IO_CONTROL_RST;
            rdata_q       <= 8'h00;
        end else begin
            cpu_control_q <= cpu_control_d;
            io_control_q  <= io_control_d;
            rdata_q       <= rdata_d;
        end
    end
    assign io_rdata = rdata_q;

    //------------------------------------------------------------
    // Mode decode
    //------------------------------------------------------------
    wire sel_stby  = cpu_control_q[`PDM_STBY_BIT];
    wire sel_idle  = cpu_control_q[`PDM_IDLE_BIT];
    wire quick     = cpu_control_q[`PDM_QUICK_BIT];
    wire io_stop   = io_control_q[`PDM_IOSTOP_BIT];

    // Target state for a sleep instruction
    function automatic pdm_pkg::pdm_state_t entry_mode(
        input logic s, input logic i, input logic st);
        if (!st)
            entry_mode = pdm_pkg::PDM_SLEEP;          // [R1]
        else if (s && !i)
            entry_mode = pdm_pkg::PDM_STANDBY;        // [R6] [R7]
        else if (!s && i)
            entry_mode = pdm_pkg::PDM_IDLE;           // [R14]
        else
            entry_mode = pdm_pkg::PDM_SYSSTOP;        // [R15]
    endfunction

    //------------------------------------------------------------
    // State machine and recovery wait
    //------------------------------------------------------------
    pdm_pkg::pdm_state_t state_q, state_d;  // Power state
    logic                 load;              // Start a wait
    logic [`PDM_CNT_W-1:0] target;           // Wait length
    logic                 cnt_run;           // Wait in progress
    logic                 cnt_done;          // Wait over
    logic                 ack_d, ack_q;      // Acknowledge pulse

    wire wake_int  = irq;           // Interrupt wake [R13]
    wire wake_any  = irq || breq;   // Interrupt or bus request

    always_comb begin
        state_d = state_q;
        load    = 1'b0;
        target  = `PDM_FRAC_COUNT;
        ack_d   = 1'b0;
        unique case (state_q)
            pdm_pkg::PDM_RUN: begin
                if (sleep_exec) begin
                    state_d = entry_mode(sel_stby, sel_idle, io_stop);
                end
            end
            pdm_pkg::PDM_SLEEP, pdm_pkg::PDM_SYSSTOP: begin
                if (wake_int) begin                   // [R1] [R3]
                    state_d = pdm_pkg::PDM_WAKE;
                    load    = 1'b1;
                    target  = `PDM_FRAC_COUNT;
                end
            end
            pdm_pkg::PDM_IDLE: begin
                if (wake_any) begin                   // [R4]
                    state_d = pdm_pkg::PDM_WAKE;
                    load    = 1'b1;
                    target  = `PDM_IDLE_COUNT + `PDM_FRAC_COUNT;
                end
            end
            pdm_pkg::PDM_STANDBY: begin
                if (wake_any) begin                   // [R8] [R9]
                    state_d = pdm_pkg::PDM_WAKE;
                    load    = 1'b1;
                    target  = quick ? `PDM_QUICK_COUNT + `PDM_FRAC_COUNT
                                    : `PDM_NORMAL_COUNT + `PDM_FRAC_COUNT;
                end
            end
            pdm_pkg::PDM_WAKE: begin
                if (!wake_any) begin
                    // Source gave up early: power down again [R10]
                    state_d = entry_mode(sel_stby, sel_idle, io_stop);
                end else if (cnt_done) begin
                    state_d = pdm_pkg::PDM_RUN;
                    ack_d   = 1'b1;                   // [R8]
                end
            end
            default: state_d = pdm_pkg::PDM_RUN;
        endcase
    end
    assign cnt_run = (state_q == pdm_pkg::PDM_WAKE);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= pdm_pkg::PDM_RUN;  // Reset leaves any mode [R11]
            ack_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            ack_q   <= ack_d;
        end
    end

    pdm_counter u_counter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .load    (load),
        .target  (target),
        .run     (cnt_run),
        .done    (cnt_done)
    );

    //------------------------------------------------------------
    // Clock enables
    //------------------------------------------------------------
    logic core_q, periph_q, osc_q, clko_q;  // Registered enables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_q   <= 1'b1;  // Clocks resume under reset [R12]
            periph_q <= 1'b1;
            osc_q    <= 1'b1;
            clko_q   <= 1'b1;
        end else begin
            core_q   <= state_d == pdm_pkg::PDM_RUN;            // [R1] [R3]
            periph_q <= !(state_d == pdm_pkg::PDM_SYSSTOP ||
                          state_d == pdm_pkg::PDM_IDLE ||
                          state_d == pdm_pkg::PDM_STANDBY ||
                          (state_d == pdm_pkg::PDM_RUN && io_control_d[`PDM_IOSTOP_BIT]));  // [R2]
            osc_q    <= state_d != pdm_pkg::PDM_STANDBY;        // [R5]
            clko_q   <= !(state_d == pdm_pkg::PDM_IDLE ||
                          state_d == pdm_pkg::PDM_STANDBY);     // [R4] [R5]
        end
    end
    assign core_run     = core_q;
    assign periph_run   = periph_q;
    assign osc_run      = osc_q;
    assign clock_output = clko_q;
    assign wake_ack     = ack_q;
    assign start_addr   = `PDM_RESET_VECTOR;  // [R11]

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    // Enables are registered from state_d, so they line up with state_q
    property p_standby_osc;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_STANDBY |-> !osc_run;
    endproperty
    a_standby_osc: assert property (p_standby_osc) else $error("osc runs in standby"); // [R5]

    property p_sleep_core;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_SLEEP |-> !core_run && periph_run;
    endproperty
    a_sleep_core: assert property (p_sleep_core) else $error("sleep gating wrong"); // [R1]

    property p_idle_clko;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_IDLE |-> !clock_output && osc_run;
    endproperty
    a_idle_clko: assert property (p_idle_clko) else $error("idle gating wrong"); // [R4]

    property p_sys_stop;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_SYSSTOP |-> !periph_run && clock_output;
    endproperty
    a_sys_stop: assert property (p_sys_stop) else $error("system stop gating wrong"); // [R3]

    property p_fallback;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_WAKE && !wake_any |=> state_q != pdm_pkg::PDM_RUN && !wake_ack;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no fall back"); // [R10]

    property p_idle_wait;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_IDLE && wake_any ##1 wake_any [*8] |-> !wake_ack;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("idle wake too soon"); // [R4]

    property p_entry;
        @(posedge ref_clk) disable iff (rst)
        state_q == pdm_pkg::PDM_RUN && sleep_exec && io_stop && sel_stby && !sel_idle
        |=> state_q == pdm_pkg::PDM_STANDBY;
    endproperty
    a_entry: assert property (p_entry) else $error("standby not entered"); // [R6]

    property p_ack_run;
        @(posedge ref_clk) disable iff (rst)
        wake_ack |-> state_q == pdm_pkg::PDM_RUN && $past(state_q) == pdm_pkg::PDM_WAKE;
    endproperty
    a_ack_run: assert property (p_ack_run) else $error("ack without wait"); // [R8]

    c_standby: cover property (@(posedge ref_clk) state_q == pdm_pkg::PDM_STANDBY);
    c_idle_wake: cover property (@(posedge ref_clk) $past(state_q) == pdm_pkg::PDM_IDLE
                                 ##[1:20] wake_ack);
    c_fall: cover property (@(posedge ref_clk) state_q == pdm_pkg::PDM_WAKE ##1
                            state_q == pdm_pkg::PDM_STANDBY);
endmodule // pdm_ctrl
`default_nettype wire

/* test/pdm_wake_src.sv */
/*
 * Wake source model: the interrupt and bus request lines.
 * Assumes the controller's one-cycle wake_ack pulse on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pdm_wake_src (
    input  wire logic ref_clk,        // System clock
    input  wire logic wake_ack,       // Acknowledge from controller
    output logic      irq_in,         // Interrupt request
    output logic      bus_request_in  // Bus request
);
    // Lines idle low
    initial begin
        irq_in = 1'b0;
        bus_request_in = 1'b0;
    end
    // Hold request until ack or hold_max cycles, then release
    task automatic wake(input logic use_bus, input int hold_max,
                        output int cycles, output logic got);
        cycles = 0;
        got = 1'b0;
        @(posedge ref_clk);
        #1;
        if (use_bus) begin
            bus_request_in = 1'b1;
        end else begin
            irq_in = 1'b1;
        end
        // Look just after each edge, once the acknowledge has settled
        while (!got && cycles < hold_max) begin
            @(posedge ref_clk);
            #1;
            cycles++;
            got = (wake_ack === 1'b1);
        end
        irq_in = 1'b0;
        bus_request_in = 1'b0;
    endtask
endmodule // pdm_wake_src
`default_nettype wire

/* test/tb_top.sv */
/*
 * Testbench of the power-down mode controller: mode entry, wake timing,
 * fallback, reset exit and register access.
 * Assumes pdm_ctrl and the wake source model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_regs.svh"
module tb_top;
    logic        ref_clk, rst, io_wr, io_rd, sleep_exec, irq_in, bus_request_in;
    logic        wake_ack, core_run, periph_run, osc_run, clock_output, got;
    logic [7:0]  io_addr, io_wdata, io_rdata, rd;
    logic [15:0] start_addr;
    int          err_count, num_checks, cyc;
    // Mode table: sleep, system stop, idle, quick standby
    logic [7:0]  cc_t [4] = '{8'h00, 8'h00, 8'h08, 8'hc0};
    logic [7:0]  ic_t [4] = '{8'h00, 8'h20, 8'h20, 8'h20};
    logic [3:0]  en_t [4] = '{4'b0111, 4'b0011, 4'b0010, 4'b0000};
    logic        bus_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    int          n_t [4] = '{`PDM_FRAC_COUNT, `PDM_FRAC_COUNT,
                             `PDM_IDLE_COUNT + `PDM_FRAC_COUNT,
                             `PDM_QUICK_COUNT + `PDM_FRAC_COUNT};

    pdm_ctrl pdm_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .sleep_exec(sleep_exec), .irq_in(irq_in), .bus_request_in(bus_request_in),
        .wake_ack(wake_ack), .core_run(core_run), .periph_run(periph_run),
        .osc_run(osc_run), .clock_output(clock_output), .start_addr(start_addr));
    pdm_wake_src pdm_wake_src_inst (.ref_clk(ref_clk), .wake_ack(wake_ack),
        .irq_in(irq_in), .bus_request_in(bus_request_in));

    // Clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic check(input string what, input logic [17:0] seen,
                         input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic io_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
        @(posedge ref_clk);
        #1 io_wr = 1'b0;
    endtask
    task automatic io_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 {io_addr, io_rd} = {a, 1'b1};
        @(posedge ref_clk);
        #1 io_rd = 1'b0;
        d = io_rdata;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Mode bits, stop bit, then sleep instruction
    task automatic enter(input logic [7:0] cc, input logic [7:0] ic);
        io_write(`PDM_CPU_CONTROL_ADDR, cc);
        io_write(`PDM_IO_CONTROL_ADDR, ic);
        @(posedge ref_clk);
        #1 sleep_exec = 1'b1;
        @(posedge ref_clk);
        #1 sleep_exec = 1'b0;
        cycles(3);
    endtask
    function automatic logic [3:0] en();
        return {core_run, periph_run, osc_run, clock_output};
    endfunction
    // -------------------------------------------------------------
    // Sequence
    // -------------------------------------------------------------
    initial begin
        {io_addr, io_wdata, io_wr, io_rd, sleep_exec} = '0;
        err_count = 0;
        num_checks = 0;
        rst = 1'b1;
        cycles(10);
        rst = 1'b0;
        // Reset values and register access
        io_read(`PDM_CPU_CONTROL_ADDR, rd);
        check("cpu_control reset", rd, `PDM_CPU_CONTROL_RST);
        io_read(`PDM_IO_CONTROL_ADDR, rd);
        check("io_control reset", rd, `PDM_IO_CONTROL_RST);
        check("enables reset", en(), 4'hf);
        check("start_addr", start_addr, `PDM_RESET_VECTOR);
        io_write(`PDM_CPU_CONTROL_ADDR, 8'h48);
        io_write(8'h20, 8'hff);
        io_read(`PDM_CPU_CONTROL_ADDR, rd);
        check("cpu_control rw", rd, 8'h48);
        io_read(8'h20, rd);
        check("unmapped read", rd, 8'h00);
        $display("test registers done");
        // I/O stop while running, cleared by software
        io_write(`PDM_IO_CONTROL_ADDR, 8'h20);
        cycles(3);
        check("io stop enables", en(), 4'b1011);
        io_write(`PDM_IO_CONTROL_ADDR, 8'h00);
        cycles(3);
        check("io stop cleared", en(), 4'hf);
        $display("test io stop done");
        // Each power-down mode: enables, wake source and recovery time
        for (int m = 0; m < 4; m++) begin
            enter(cc_t[m], ic_t[m]);
            check("mode enables", en(), en_t[m]);
            pdm_wake_src_inst.wake(bus_t[m], 200, cyc, got);
            check("wake ack", got, 1'b1);
            // Two sync flops and one decode edge come before the count
            check("wake time", cyc[17:0], n_t[m][17:0] + 18'h3);
            cycles(1);
            check("core after wake", core_run, 1'b1);
            io_write(`PDM_IO_CONTROL_ADDR, 8'h00);
        end
        $display("test modes done");
        // Normal standby: request dropped early falls back to standby
        enter(8'h40, 8'h20);
        pdm_wake_src_inst.wake(1'b0, 50, cyc, got);
        check("early ack", got, 1'b0);
        cycles(6);
        check("fallback enables", en(), 4'b0000);
        $display("test fallback done");
        // Reset while in standby restarts clocks during reset
        rst = 1'b1;
        cycles(3);
        check("osc and clock in reset", {osc_run, clock_output}, 2'b11);
        cycles(7);
        rst = 1'b0;
        cycles(2);
        check("run after reset", en(), 4'hf);
        check("start_addr after reset", start_addr, `PDM_RESET_VECTOR);
        $display("test reset exit done");
        complete_run();
    end
    // Watchdog, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("ERROR watchdog expected done seen timeout");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
